/* File: smc_regs.svh */
// constants for the sleep mode clock gating block
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_NOISE 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_RSV4 3'h4
`define SMC_MODE_RSV5 3'h5
`define SMC_MODE_STBY 3'h6
`define SMC_MODE_XSTBY 3'h7
`define SMC_HALT_EXTRA 3'h4
`define SMC_STBY_WAKE 16'h0006
`define SMC_CNT_ZERO 16'h0000
`define SMC_CNT_ONE 16'h0001
`define SMC_HALT_ZERO 3'h0
`define SMC_HALT_ONE 3'h1
`define SMC_AGE_ZERO 17'h00000
`define SMC_AGE_ONE 17'h00001
`define SMC_AGE_LIMIT 17'h0FFFF
`endif

/* File: smc_pkg.sv */
// types for the sleep mode clock gating block
package smc_pkg;
   typedef enum logic [2:0] {
      SMC_RUN = 3'h0,
      SMC_SLEEP = 3'h1,
      SMC_START = 3'h3,
      SMC_HALT = 3'h2
   } smc_state_t;
endpackage : smc_pkg

/* File: smc_sleep_ctrl.sv */
// sleep controller: gates clock domains and sequences wake-up
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"

// What this block does
// - sleep entered only when halt instruction executes with arm bit set
// - after wake by interrupt, core held four more cycles past start-up
// - register file and SRAM kept intact; this block never resets them
// - reset during sleep wakes device and restarts from reset vector
// - mode 000 idle: only core and program-memory clocks stop
// - idle wakes on any enabled internal or external interrupt
// - idle with comparator disabled: comparator interrupt cannot wake
// - converter enabled: entering idle or noise mode starts conversion
// - mode 001 noise reduction: I/O, core, program clocks stop
// - noise mode wakes on converter, resets, address, timer0, store, pins
// - mode 010 power-down: oscillator and all generated clocks stop
// - power-down wakes on resets, address match, upper level, lower pins
// - power-down exit waits start-up delay set by clock-select fuses
// - mode 011 power-save: like power-down, async timer runs if selected
// - power-save timer0 wake needs its mask bit and global enable
// - async timer registers undefined after power-save without async clock
// - mode 110 standby needs crystal; oscillator runs; wakes in 6 cycles
// - mode 111 extended standby needs crystal; wakes in six cycles
// - select occupies control bits 4:2; codes 100 and 101 reserved
module smc_sleep_ctrl
   import smc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sleepArmBit,
   input wire logic [2:0] sleepModeSelect,
   input wire logic haltExec,
   input wire logic crystalClock,
   input wire logic [15:0] startupCycles,
   input wire logic globalIrqEnable,
   input wire logic asyncTimerClockSel,
   input wire logic comparatorDisableBit,
   input wire logic converterEnable,
   input wire logic [7:0] extIrqPins,
   input wire logic [3:0] upperLevelMode,
   input wire logic comparatorIrq,
   input wire logic converterDoneIrq,
   input wire logic addrMatchIrq,
   input wire logic timer0OvfIrq,
   input wire logic timer0CmpIrq,
   input wire logic [1:0] timer0IrqMask,
   input wire logic storeReadyIrq,
   input wire logic otherIoIrq,
   input wire logic resetWake,
   output logic coreClockEn,
   output logic programMemoryClockEn,
   output logic peripheralClockEn,
   output logic converterClockEn,
   output logic asyncTimerClockEn,
   output logic mainOscEn,
   output logic converterStart,
   output logic resumeIrq,
   output logic resumeReset,
   output logic sleeping
);

   smc_state_t state;
   smc_state_t next_state;
   logic [2:0] mode;
   logic [15:0] waitCnt;
   logic [2:0] haltCnt;
   logic wakeSrc;
   logic modeOk;
   logic wakeByReset;

   // valid mode check: reserved codes and crystal-less standby refused
   function automatic logic smc_mode_valid(input logic [2:0] m, input logic xtal);
      case (m)
         `SMC_MODE_RSV4, `SMC_MODE_RSV5: smc_mode_valid = 1'b0;
         `SMC_MODE_STBY, `SMC_MODE_XSTBY: smc_mode_valid = xtal;
         default: smc_mode_valid = 1'b1;
      endcase
   endfunction : smc_mode_valid

   // timer0 wake term gated by mask and global enable
   function automatic logic smc_t0_wake(input logic ovf, input logic cmp, input logic [1:0] msk,
                                        input logic gie);
      smc_t0_wake = gie && ((ovf && msk[0]) || (cmp && msk[1]));
   endfunction : smc_t0_wake

   assign modeOk = smc_mode_valid(sleepModeSelect, crystalClock);

   logic pinWake;
   logic t0Wake;
   assign pinWake = (|extIrqPins[3:0]) || (|(extIrqPins[7:4] & upperLevelMode));
   assign t0Wake = smc_t0_wake(timer0OvfIrq, timer0CmpIrq, timer0IrqMask, globalIrqEnable);

   always_comb begin
      case (mode)
         `SMC_MODE_IDLE: wakeSrc = (|extIrqPins) || addrMatchIrq || timer0OvfIrq || timer0CmpIrq ||
                                   storeReadyIrq || converterDoneIrq || otherIoIrq ||
                                   (comparatorIrq && !comparatorDisableBit);
         `SMC_MODE_NOISE: wakeSrc = converterDoneIrq || addrMatchIrq || timer0OvfIrq || timer0CmpIrq ||
                                    storeReadyIrq || pinWake;
         `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: wakeSrc = addrMatchIrq || pinWake ||
                                                      (asyncTimerClockSel && t0Wake);
         default: wakeSrc = addrMatchIrq || pinWake;
      endcase
   end

   always_comb begin
      next_state = state;
      case (state)
         SMC_RUN: if (haltExec && sleepArmBit && modeOk) begin
            next_state = SMC_SLEEP;
         end
         SMC_SLEEP: if (resetWake || wakeSrc) begin
            next_state = SMC_START;
         end
         SMC_START: if (waitCnt <= `SMC_CNT_ONE) begin
            next_state = wakeByReset ? SMC_RUN : SMC_HALT;
         end
         SMC_HALT: if (haltCnt == `SMC_HALT_ONE) begin
            next_state = SMC_RUN;
         end
         default: next_state = SMC_RUN;
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= SMC_RUN;
      end else begin
         state <= next_state;
      end
   end

   // mode latch and wake cause
   always_ff @(posedge clk) begin
      if (rst) begin
         mode <= `SMC_MODE_IDLE;
         wakeByReset <= 1'b0;
      end else begin
         if (state == SMC_RUN && next_state == SMC_SLEEP) begin
            mode <= sleepModeSelect;
            wakeByReset <= 1'b0;
         end
         if (state == SMC_SLEEP && resetWake) begin
            wakeByReset <= 1'b1;
         end
      end
   end

   // start-up and halt counters
   always_ff @(posedge clk) begin
      if (rst) begin
         waitCnt <= `SMC_CNT_ZERO;
         haltCnt <= `SMC_HALT_ZERO;
      end else begin
         if (state == SMC_SLEEP) begin
            case (mode)
               `SMC_MODE_STBY, `SMC_MODE_XSTBY: waitCnt <= `SMC_STBY_WAKE;
               `SMC_MODE_PDOWN, `SMC_MODE_PSAVE: waitCnt <= startupCycles;
               default: waitCnt <= `SMC_CNT_ONE;
            endcase
         end else if (state == SMC_START && waitCnt != `SMC_CNT_ZERO) begin
            waitCnt <= waitCnt - `SMC_CNT_ONE;
         end
         if (state == SMC_START) begin
            haltCnt <= `SMC_HALT_EXTRA;
         end else if (state == SMC_HALT) begin
            haltCnt <= haltCnt - `SMC_HALT_ONE;
         end
      end
   end

   // clock enables per mode; register file and memory are only clock-gated, never cleared
   always_ff @(posedge clk) begin
      if (rst) begin
         coreClockEn <= 1'b1;
         programMemoryClockEn <= 1'b1;
         peripheralClockEn <= 1'b1;
         converterClockEn <= 1'b1;
         asyncTimerClockEn <= 1'b1;
         mainOscEn <= 1'b1;
         sleeping <= 1'b0;
      end else if (next_state == SMC_SLEEP) begin
         coreClockEn <= 1'b0;
         programMemoryClockEn <= 1'b0;
         sleeping <= 1'b1;
         case (state == SMC_RUN ? sleepModeSelect : mode)
            `SMC_MODE_IDLE: begin
               peripheralClockEn <= 1'b1;
               converterClockEn <= 1'b1;
               asyncTimerClockEn <= 1'b1;
               mainOscEn <= 1'b1;
            end
            `SMC_MODE_NOISE: begin
               peripheralClockEn <= 1'b0;
               converterClockEn <= 1'b1;
               asyncTimerClockEn <= 1'b1;
               mainOscEn <= 1'b1;
            end
            `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: begin
               peripheralClockEn <= 1'b0;
               converterClockEn <= 1'b0;
               asyncTimerClockEn <= asyncTimerClockSel;
               mainOscEn <= (state == SMC_RUN ? sleepModeSelect : mode) == `SMC_MODE_XSTBY;
            end
            `SMC_MODE_STBY: begin
               peripheralClockEn <= 1'b0;
               converterClockEn <= 1'b0;
               asyncTimerClockEn <= 1'b0;
               mainOscEn <= 1'b1;
            end
            default: begin
               peripheralClockEn <= 1'b0;
               converterClockEn <= 1'b0;
               asyncTimerClockEn <= 1'b0;
               mainOscEn <= 1'b0;
            end
         endcase
      end else if (next_state == SMC_START) begin
         peripheralClockEn <= 1'b1;
         converterClockEn <= 1'b1;
         asyncTimerClockEn <= 1'b1;
         mainOscEn <= 1'b1;
         sleeping <= 1'b1;
      end else begin
         coreClockEn <= (next_state == SMC_RUN);
         programMemoryClockEn <= (next_state == SMC_RUN);
         peripheralClockEn <= 1'b1;
         converterClockEn <= 1'b1;
         asyncTimerClockEn <= 1'b1;
         mainOscEn <= 1'b1;
         sleeping <= (next_state != SMC_RUN);
      end
   end

   // event pulses to core and converter
   always_ff @(posedge clk) begin
      if (rst) begin
         converterStart <= 1'b0;
         resumeIrq <= 1'b0;
         resumeReset <= 1'b0;
      end else begin
         converterStart <= state == SMC_RUN && next_state == SMC_SLEEP && converterEnable &&
                           (sleepModeSelect == `SMC_MODE_IDLE || sleepModeSelect == `SMC_MODE_NOISE);
         resumeIrq <= state == SMC_HALT && next_state == SMC_RUN;
         resumeReset <= state == SMC_START && next_state == SMC_RUN;
      end
   end

   // reset-wake age counter: bounds how long a reset wake may take to resume
   logic resetPend;
   logic [16:0] resetAge;
   always_ff @(posedge clk) begin
      if (rst || resumeReset) begin
         resetPend <= 1'b0;
         resetAge <= `SMC_AGE_ZERO;
      end else if (state == SMC_SLEEP && resetWake) begin
         resetPend <= 1'b1;
         resetAge <= `SMC_AGE_ZERO;
      end else if (resetPend) begin
         resetAge <= resetAge + `SMC_AGE_ONE;
      end
   end

   property p_no_sleep_unarmed;
      @(posedge clk) disable iff (rst)
      (state == SMC_RUN && haltExec && !sleepArmBit) |=> state == SMC_RUN;
   endproperty
   a_no_sleep_unarmed: assert property (p_no_sleep_unarmed) else $error("slept without arm bit");

   property p_enter;
      @(posedge clk) disable iff (rst)
      (state == SMC_RUN && haltExec && sleepArmBit && modeOk) |=> (sleeping && !coreClockEn && !programMemoryClockEn);
   endproperty
   a_enter: assert property (p_enter) else $error("sleep not entered");

   property p_reserved;
      @(posedge clk) disable iff (rst)
      (state == SMC_RUN && haltExec && sleepArmBit && !modeOk) |=> (state == SMC_RUN && !sleeping);
   endproperty
   a_reserved: assert property (p_reserved) else $error("invalid mode slept");

   property p_halt4;
      @(posedge clk) disable iff (rst)
      $rose(state == SMC_HALT) |-> (state == SMC_HALT)[*4] ##1 state == SMC_RUN;
   endproperty
   a_halt4: assert property (p_halt4) else $error("halt not four cycles");

   property p_stby6;
      @(posedge clk) disable iff (rst)
      (state == SMC_SLEEP && mode == `SMC_MODE_STBY && wakeSrc && !resetWake) |=> (state == SMC_START)[*6];
   endproperty
   a_stby6: assert property (p_stby6) else $error("standby wake not six cycles");

   property p_idle_clocks;
      @(posedge clk) disable iff (rst)
      (sleeping && state == SMC_SLEEP && mode == `SMC_MODE_IDLE) |-> peripheralClockEn && mainOscEn;
   endproperty
   a_idle_clocks: assert property (p_idle_clocks) else $error("idle stopped io clock");

   property p_pdown_clocks;
      @(posedge clk) disable iff (rst)
      (state == SMC_SLEEP && $past(state) == SMC_SLEEP && mode == `SMC_MODE_PDOWN) |-> !mainOscEn && !asyncTimerClockEn;
   endproperty
   a_pdown_clocks: assert property (p_pdown_clocks) else $error("power-down left clocks on");

   property p_reset_wake;
      @(posedge clk) disable iff (rst)
      (state == SMC_SLEEP && resetWake) |=> (state == SMC_START && wakeByReset);
   endproperty
   a_reset_wake: assert property (p_reset_wake) else $error("reset wake lost");

   property p_reset_age;
      @(posedge clk) disable iff (rst)
      resetPend |-> resetAge <= `SMC_AGE_LIMIT;
   endproperty
   a_reset_age: assert property (p_reset_age) else $error("reset wake never resumed");

   property p_resume_core;
      @(posedge clk) disable iff (rst)
      resumeIrq |-> (coreClockEn && programMemoryClockEn && !sleeping);
   endproperty
   a_resume_core: assert property (p_resume_core) else $error("resumed with core clock off");

   property p_conv;
      @(posedge clk) disable iff (rst)
      (state == SMC_RUN && haltExec && sleepArmBit && converterEnable && sleepModeSelect == `SMC_MODE_IDLE)
         |=> converterStart;
   endproperty
   a_conv: assert property (p_conv) else $error("conversion not started");

   c_idle_irq: cover property (@(posedge clk) disable iff (rst) state == SMC_HALT ##4 resumeIrq);
   c_pdown: cover property (@(posedge clk) disable iff (rst) state == SMC_SLEEP && mode == `SMC_MODE_PDOWN);
   c_reset: cover property (@(posedge clk) disable iff (rst) resumeReset);
   c_xstby: cover property (@(posedge clk) disable iff (rst) state == SMC_START && mode == `SMC_MODE_XSTBY);
   c_psave_t0: cover property (@(posedge clk) disable iff (rst) state == SMC_SLEEP && mode == `SMC_MODE_PSAVE && t0Wake);

endmodule : smc_sleep_ctrl
`default_nettype wire

/* File: smc_core_model.sv */
// core-side model: arms, issues the halt pulse, disarms after waking
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic sleepReq,
   input wire logic armWanted,
   input wire logic resumeIrq,
   input wire logic resumeReset,
   output logic sleepArmBit,
   output logic haltExec
);
   logic pend;
   always_ff @(posedge clk) begin
      if (rst || resumeIrq || resumeReset) begin
         sleepArmBit <= 1'b0;
      end else if (sleepReq) begin
         sleepArmBit <= armWanted;
      end
   end
   always_ff @(posedge clk) begin
      pend <= sleepReq && !rst;
      haltExec <= pend && !rst;
   end
endmodule : smc_core_model
`default_nettype wire

/* File: tb_top.sv */
// bench for the sleep controller: mode table, then wake cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [2:0] mode;
      logic xtal;
      logic arm;
      logic slp;
      logic [5:0] en;
   } smc_row_t;
   localparam smc_row_t ROWS [11] = '{
      '{3'h0, 1'b1, 1'b1, 1'b1, 6'h0F}, '{3'h1, 1'b1, 1'b1, 1'b1, 6'h07},
      '{3'h2, 1'b1, 1'b1, 1'b1, 6'h00}, '{3'h3, 1'b1, 1'b1, 1'b1, 6'h02},
      '{3'h6, 1'b1, 1'b1, 1'b1, 6'h01}, '{3'h7, 1'b1, 1'b1, 1'b1, 6'h03},
      '{3'h4, 1'b1, 1'b1, 1'b0, 6'h3F}, '{3'h5, 1'b1, 1'b1, 1'b0, 6'h3F},
      '{3'h6, 1'b0, 1'b1, 1'b0, 6'h3F}, '{3'h7, 1'b0, 1'b1, 1'b0, 6'h3F},
      '{3'h2, 1'b1, 1'b0, 1'b0, 6'h3F}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sleepReq, armWanted, sleepArmBit, haltExec, crystalClock, globalIrqEnable;
   logic asyncTimerClockSel, comparatorDisableBit, converterEnable, comparatorIrq;
   logic converterDoneIrq, addrMatchIrq, timer0OvfIrq, timer0CmpIrq, storeReadyIrq;
   logic otherIoIrq, resetWake, coreClockEn, programMemoryClockEn, peripheralClockEn;
   logic converterClockEn, asyncTimerClockEn, mainOscEn, converterStart, resumeIrq;
   logic resumeReset, sleeping;
   logic [2:0] sleepModeSelect;
   logic [15:0] startupCycles;
   logic [7:0] extIrqPins;
   logic [3:0] upperLevelMode;
   logic [1:0] timer0IrqMask;
   logic [5:0] ens;
   int badCount = 0;
   int checks = 0;
   int starts = 0;
   int lat0, lat3, lat8, latS, latX;
   assign ens = {coreClockEn, programMemoryClockEn, peripheralClockEn, converterClockEn, asyncTimerClockEn, mainOscEn};
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (converterStart === 1'b1) starts++;
   end
   smc_sleep_ctrl dut (
      .clk, .rst, .sleepArmBit, .sleepModeSelect, .haltExec, .crystalClock, .startupCycles,
      .globalIrqEnable, .asyncTimerClockSel, .comparatorDisableBit, .converterEnable, .extIrqPins,
      .upperLevelMode, .comparatorIrq, .converterDoneIrq, .addrMatchIrq, .timer0OvfIrq, .timer0CmpIrq,
      .timer0IrqMask, .storeReadyIrq, .otherIoIrq, .resetWake, .coreClockEn, .programMemoryClockEn,
      .peripheralClockEn, .converterClockEn, .asyncTimerClockEn, .mainOscEn, .converterStart,
      .resumeIrq, .resumeReset, .sleeping);
   smc_core_model core (.clk, .rst, .sleepReq, .armWanted, .resumeIrq, .resumeReset, .sleepArmBit, .haltExec);
   task automatic step();
      @(posedge clk);
      #2;
   endtask : step
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk
   task automatic clrSrc();
      {comparatorIrq, converterDoneIrq, addrMatchIrq, timer0OvfIrq, timer0CmpIrq} = 5'h00;
      {storeReadyIrq, otherIoIrq, resetWake} = 3'h0;
      extIrqPins = 8'h00;
   endtask : clrSrc
   task automatic doHalt();
      sleepReq = 1'b1;
      step();
      sleepReq = 1'b0;
      repeat (4) step();
   endtask : doHalt
   task automatic noWake();
      repeat (30) step();
      chk("asleep", sleeping, 1'b1);
   endtask : noWake
   // wake sources are held until the resume pulse
   task automatic waitFor(input logic rs, output int lat);
      lat = 0;
      while ((rs ? resumeReset : resumeIrq) !== 1'b1) begin
         step();
         lat++;
         if (lat > 300) begin
            chk("wake timeout", 16'h0001, 16'h0000);
            conclude();
         end
      end
      if (!rs) chk("core on at resume", coreClockEn, 1'b1);
      clrSrc();
      step();
      chk("awake", sleeping, 1'b0);
   endtask : waitFor
   initial begin
      {sleepReq, armWanted, globalIrqEnable, comparatorDisableBit, converterEnable} = 5'h00;
      clrSrc();
      {crystalClock, asyncTimerClockSel} = 2'h3;
      sleepModeSelect = 3'h0;
      startupCycles = 16'h0003;
      upperLevelMode = 4'h0;
      timer0IrqMask = 2'h0;
      repeat (20) @(posedge clk);
      #2;
      rst = 1'b0;
      chk("reset enables", ens, 6'h3F);
      chk("reset sleeping", sleeping, 1'b0);
      foreach (ROWS[i]) begin
         sleepModeSelect = ROWS[i].mode;
         crystalClock = ROWS[i].xtal;
         armWanted = ROWS[i].arm;
         doHalt();
         chk("sleeping", sleeping, ROWS[i].slp);
         chk("enables", ens, ROWS[i].en);
         if (ROWS[i].slp) begin
            resetWake = 1'b1;
            waitFor(1'b1, lat0);
         end
      end
      chk("no start when off", starts, 0);
      crystalClock = 1'b1;
      armWanted = 1'b1;
      {converterEnable, comparatorDisableBit} = 2'h3;
      sleepModeSelect = 3'h0;
      doHalt();
      chk("idle start", starts, 1);
      comparatorIrq = 1'b1;
      noWake();
      otherIoIrq = 1'b1;
      waitFor(1'b0, lat0);
      sleepModeSelect = 3'h1;
      doHalt();
      chk("noise start", starts, 2);
      otherIoIrq = 1'b1;
      noWake();
      converterDoneIrq = 1'b1;
      waitFor(1'b0, lat3);
      converterEnable = 1'b0;
      sleepModeSelect = 3'h2;
      doHalt();
      {timer0OvfIrq, storeReadyIrq, globalIrqEnable} = 3'h7;
      timer0IrqMask = 2'h3;
      extIrqPins = 8'h10;
      noWake();
      extIrqPins = 8'h11;
      waitFor(1'b0, lat3);
      chk("idle vs pd delay", lat3 - lat0, 2);
      upperLevelMode = 4'h1;
      doHalt();
      extIrqPins = 8'h10;
      waitFor(1'b0, lat0);
      startupCycles = 16'h0008;
      doHalt();
      addrMatchIrq = 1'b1;
      waitFor(1'b0, lat8);
      chk("pd start-up", lat8 - lat3, 5);
      sleepModeSelect = 3'h3;
      timer0IrqMask = 2'h1;
      globalIrqEnable = 1'b0;
      doHalt();
      timer0OvfIrq = 1'b1;
      noWake();
      globalIrqEnable = 1'b1;
      waitFor(1'b0, lat0);
      sleepModeSelect = 3'h6;
      doHalt();
      addrMatchIrq = 1'b1;
      waitFor(1'b0, latS);
      chk("standby delay", latS - lat8, 16'hFFFE);
      sleepModeSelect = 3'h7;
      timer0IrqMask = 2'h2;
      doHalt();
      timer0CmpIrq = 1'b1;
      waitFor(1'b0, latX);
      chk("ext standby delay", latX, latS);
      sleepModeSelect = 3'h2;
      doHalt();
      chk("asleep before reset", sleeping, 1'b1);
      rst = 1'b1;
      step();
      rst = 1'b0;
      chk("mid reset enables", ens, 6'h3F);
      chk("mid reset sleeping", sleeping, 1'b0);
      sleepModeSelect = 3'h0;
      doHalt();
      otherIoIrq = 1'b1;
      waitFor(1'b0, lat0);
      chk("idle wake after reset", lat0, 16'h0006);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
